//--- sas_pkg.sv
package sas_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] SAS_OFS_CTRL   = 4'h0;
  localparam logic [3:0] SAS_OFS_STAT   = 4'h4;
  localparam logic [3:0] SAS_OFS_RES    = 4'h8;
  localparam logic [3:0] SAS_OFS_CNT    = 4'hc;

  // Field positions and reset values
  localparam int         SAS_CTRL_EN_BIT  = 0;
  localparam int         SAS_STAT_ACT_BIT = 8;
  localparam logic       SAS_EN_RST       = 1'b1;
  localparam logic [1:0] SAS_PD_RST       = 2'b00;

  // Serial frame counts, in serial clock edges, and the first trial mask
  localparam logic [4:0] SAS_MUX_EDGE  = 5'h04;
  localparam logic [4:0] SAS_SGL_EDGE  = 5'h06;
  localparam logic [4:0] SAS_CTRL_LEN  = 5'h08;
  localparam logic [4:0] SAS_CONV_LEN  = 5'h10;
  localparam logic [15:0] SAS_MSB_MASK = 16'h8000;

  // Power mode codes
  localparam logic [1:0] SAS_PD_AUTO = 2'b00;
  localparam logic [1:0] SAS_PD_RSV  = 2'b01;
  localparam logic [1:0] SAS_PD_INT  = 2'b10;
  localparam logic [1:0] SAS_PD_ON   = 2'b11;

  typedef struct packed {
    logic       start;
    logic [2:0] chan;
    logic       spare;
    logic       sgl;
    logic [1:0] pd;
  } sas_ctrl_t;

  typedef struct packed {
    logic [7:0] pos;
    logic [7:0] neg;
    logic       common_return_input;
  } sas_mux_t;

  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_CTRL = 2'b01,
    SAS_CONV = 2'b11,
    SAS_DONE = 2'b10
  } sas_phase_t;

endpackage : sas_pkg

//--- sas_sequencer.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
// Operation
// - The link has four wires, chip select, serial clock, data in and data out, and the host drives the clock.
// - Once the channel bits are in, the multiplexer is set and acquisition starts.
// - Four clocks after acquisition starts the byte is complete and conversion starts.
// - At conversion start the sample-and-hold goes to hold for the whole conversion.
// - The conversion runs over the next sixteen serial clocks.
// - With the compact scheme a conversion takes three byte transfers, 24 clocks.
// - With single-ended select high the chosen channel is positive and the common return negative.
// - With single-ended select low codes 0-3 pick pairs with the even input positive, codes 4-7 swap polarity.
// - The result is 16 bits and one step is the reference divided by 65536.
// - The byte opens with a high start bit and data in is ignored until it is seen.
// - The byte carries, first to last, start, three channel bits, a spare, single-ended select, two power bits.
// - Busy is high for one clock after the byte, then 16 falling edges put out the result.
// - Power bits 00 power down between conversions, 10 internal clock, 11 always on, 01 reserved; 10 runs like 11 here, on the serial clock.
module sas_sequencer
  import sas_pkg::*;
(
  // System clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Serial link
  input  wire logic        serial_clock_in_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  output logic             busy_o,
  output logic             busy_oe_o,
  // Analog front end
  input  wire logic        comp_i,
  output logic      [15:0] dac_trial_o,
  output sas_mux_t         mux_o,
  output logic             acquire_o,
  output logic             hold_o,
  output logic             powered_o,
  output logic      [1:0]  pwr_mode_o
);

  function automatic sas_mux_t sas_mux_dec(input logic [2:0] chan, input logic sgl);
    sas_mux_t   m;
    logic [7:0] even;
    logic [7:0] odd;
    m    = '0;
    even = 8'h01 << {chan[1:0], 1'b0};
    odd  = 8'h02 << {chan[1:0], 1'b0};
    if (sgl) begin
      m.pos = 8'h01 << chan;
      m.common_return_input = 1'b1;
    end else begin
      m.pos = chan[2] ? odd : even;
      m.neg = chan[2] ? even : odd;
    end
    return m;
  endfunction : sas_mux_dec

  // System side state
  logic        sys_rst_reg;
  logic        en_reg;
  logic        cs_meta_reg;
  logic        cs_sync_reg;
  logic        oe_reg;
  logic        tgl_meta_reg;
  logic        tgl_sync_reg;
  logic        tgl_prev_reg;
  logic [15:0] res_sys_reg;
  logic [7:0]  byte_sys_reg;
  logic [15:0] cnt_sys_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_sel;

  // Link side state
  logic        en_meta_reg;
  logic        en_sync_reg;
  sas_phase_t  phase_reg;
  sas_phase_t  phase_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic [6:0]  byte_reg;
  logic [15:0] sar_reg;
  logic [15:0] mask_reg;
  logic [15:0] dac_reg;
  logic        acq_reg;
  logic        hold_reg;
  sas_mux_t    mux_reg;
  sas_mux_t    mux_next;
  logic [1:0]  pd_reg;
  logic        last_sgl_reg;
  logic        powered_reg;
  logic        done_tgl_reg;
  logic [15:0] res_hold_reg;
  sas_ctrl_t   byte_hold_reg;
  logic        busy_reg;
  logic        dout_reg;
  logic [4:0]  hold_len_reg;

  // Chip select high aborts a frame at once, even with the serial clock stopped
  wire         frame_rst = cs_n_i | sys_rst_reg;
  wire         start_ok  = din_i & en_sync_reg;
  wire         in_ctrl   = (phase_reg == SAS_CTRL);
  wire         in_conv   = (phase_reg == SAS_CONV);
  wire [4:0]   cnt_inc   = cnt_reg + 5'h01;
  wire         ctrl_end  = in_ctrl && (cnt_inc == SAS_CTRL_LEN);
  wire         conv_end  = in_conv && (cnt_inc == SAS_CONV_LEN);
  wire [7:0]   byte_full = {byte_reg, din_i};
  wire [15:0]  decided   = comp_i ? dac_reg : sar_reg;
  wire [4:0]   out_idx   = SAS_CONV_LEN - cnt_reg;
  wire         out_ok    = (in_conv || phase_reg == SAS_DONE) && cnt_reg != 5'h00
                           && cnt_reg <= SAS_CONV_LEN;
  wire         tgl_edge  = tgl_sync_reg ^ tgl_prev_reg;

  always_comb begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    unique case (phase_reg)
      SAS_IDLE, SAS_DONE: begin
        if (start_ok) begin
          phase_next = SAS_CTRL;
          cnt_next   = 5'h01;
        end else if (phase_reg == SAS_DONE && cnt_reg == SAS_CONV_LEN) begin
          cnt_next = cnt_inc;
        end
      end
      SAS_CTRL: begin
        phase_next = ctrl_end ? SAS_CONV : SAS_CTRL;
        cnt_next   = ctrl_end ? 5'h00 : cnt_inc;
      end
      SAS_CONV: begin
        phase_next = conv_end ? SAS_DONE : SAS_CONV;
        cnt_next   = cnt_inc;
      end
    endcase
  end

  // Mux follows the bits as they arrive, then stays frozen through the conversion
  always_comb begin
    mux_next = mux_reg;
    if (in_ctrl && cnt_inc == SAS_MUX_EDGE) begin
      mux_next = sas_mux_dec({byte_reg[1:0], din_i}, last_sgl_reg);
    end else if (in_ctrl && cnt_inc == SAS_SGL_EDGE) begin
      mux_next = sas_mux_dec(byte_reg[3:1], din_i);
    end
  end

  // System domain
  always_ff @(posedge clk_sys_i) begin
    sys_rst_reg <= srst_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      en_reg       <= SAS_EN_RST;
      cs_meta_reg  <= 1'b1;
      cs_sync_reg  <= 1'b1;
      oe_reg       <= 1'b0;
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_prev_reg <= 1'b0;
      res_sys_reg  <= 16'h0000;
      byte_sys_reg <= 8'h00;
      cnt_sys_reg  <= 16'h0000;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      if (reg_wr_i && reg_addr_i == SAS_OFS_CTRL) begin
        en_reg <= reg_wdata_i[SAS_CTRL_EN_BIT];
      end
      cs_meta_reg  <= cs_n_i;
      cs_sync_reg  <= cs_meta_reg;
      oe_reg       <= ~cs_sync_reg;
      tgl_meta_reg <= done_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_prev_reg <= tgl_sync_reg;
      if (tgl_edge) begin
        res_sys_reg  <= res_hold_reg;
        byte_sys_reg <= byte_hold_reg;
        cnt_sys_reg  <= cnt_sys_reg + 16'h0001;
      end
      rdata_reg <= reg_rd_i ? rdata_sel : 32'h0000_0000;
    end
  end

  always_comb begin
    unique case (reg_addr_i)
      SAS_OFS_CTRL: rdata_sel = {31'h0, en_reg};
      SAS_OFS_STAT: rdata_sel = {23'h0, ~cs_sync_reg, byte_sys_reg};
      SAS_OFS_RES:  rdata_sel = {16'h0, res_sys_reg};
      SAS_OFS_CNT:  rdata_sel = {16'h0, cnt_sys_reg};
      default:      rdata_sel = 32'h0000_0000;
    endcase
  end

  // Link domain, enable crossing kept alive across frames
  always_ff @(posedge serial_clock_in_i or posedge sys_rst_reg) begin
    if (sys_rst_reg) begin
      en_meta_reg <= SAS_EN_RST;
      en_sync_reg <= SAS_EN_RST;
    end else begin
      en_meta_reg <= en_reg;
      en_sync_reg <= en_meta_reg;
    end
  end

  always_ff @(posedge serial_clock_in_i or posedge frame_rst) begin
    if (frame_rst) begin
      phase_reg <= SAS_IDLE;
      cnt_reg   <= 5'h00;
      byte_reg  <= 7'h00;
      acq_reg   <= 1'b0;
      hold_reg  <= 1'b0;
      mux_reg   <= '0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      byte_reg  <= in_ctrl ? byte_full[6:0] : 7'h01;
      acq_reg   <= (in_ctrl && cnt_inc == SAS_MUX_EDGE) || (acq_reg && !ctrl_end);
      hold_reg  <= ctrl_end || (hold_reg && !conv_end);
      mux_reg   <= mux_next;
    end
  end

  // Successive approximation: comparator high means input at or above the trial code
  always_ff @(posedge serial_clock_in_i or posedge frame_rst) begin
    if (frame_rst) begin
      sar_reg  <= 16'h0000;
      mask_reg <= 16'h0000;
      dac_reg  <= 16'h0000;
    end else if (ctrl_end) begin
      sar_reg  <= 16'h0000;
      mask_reg <= SAS_MSB_MASK;
      dac_reg  <= SAS_MSB_MASK;
    end else if (in_conv) begin
      sar_reg  <= decided;
      mask_reg <= mask_reg >> 1;
      dac_reg  <= decided | (mask_reg >> 1);
    end
  end

  // State that must outlive a frame
  always_ff @(posedge serial_clock_in_i or posedge sys_rst_reg) begin
    if (sys_rst_reg) begin
      pd_reg        <= SAS_PD_RST;
      last_sgl_reg  <= 1'b1;
      powered_reg   <= 1'b0;
      done_tgl_reg  <= 1'b0;
      res_hold_reg  <= 16'h0000;
      byte_hold_reg <= '0;
    end else begin
      if (ctrl_end) begin
        pd_reg        <= byte_full[1:0];
        last_sgl_reg  <= byte_full[2];
        byte_hold_reg <= byte_full;
      end
      if (conv_end) begin
        res_hold_reg <= decided;
        done_tgl_reg <= ~done_tgl_reg;
      end
      powered_reg <= (pd_reg != SAS_PD_AUTO) || phase_next == SAS_CTRL || phase_next == SAS_CONV;
    end
  end

  // Falling edge drives busy and data out, host samples on the rising edge
  always_ff @(negedge serial_clock_in_i or posedge frame_rst) begin
    if (frame_rst) begin
      busy_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else begin
      busy_reg <= in_conv && cnt_reg == 5'h00;
      dout_reg <= out_ok ? sar_reg[out_idx[3:0]] : 1'b0;
    end
  end

  // Hold length count, so the sixteen-clock check needs no long repetition
  always_ff @(posedge serial_clock_in_i or posedge frame_rst) begin
    if (frame_rst) begin
      hold_len_reg <= 5'h00;
    end else begin
      hold_len_reg <= hold_reg ? hold_len_reg + 5'h01 : 5'h00;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign dout_o      = dout_reg;
  assign busy_o      = busy_reg;
  assign dout_oe_o   = oe_reg;
  assign busy_oe_o   = oe_reg;
  assign dac_trial_o = dac_reg;
  assign mux_o       = mux_reg;
  assign acquire_o   = acq_reg;
  assign hold_o      = hold_reg;
  assign powered_o   = powered_reg;
  assign pwr_mode_o  = pd_reg;

  AST_ACQ_AT_MUX: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    in_ctrl && cnt_reg == 5'h03 |=> acq_reg && !hold_reg)
    else $error("acquisition did not start after the channel bits");

  AST_CONV_AFTER_FOUR: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    $rose(acq_reg) |-> !hold_reg ##4 (hold_reg && !acq_reg))
    else $error("conversion did not start four clocks after acquisition");

  AST_HOLD_IN_CONV: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    in_conv |-> hold_reg && !acq_reg)
    else $error("sample-and-hold not in hold during conversion");

  AST_SIXTEEN_CLOCKS: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    $fell(hold_reg) |-> hold_len_reg == SAS_CONV_LEN)
    else $error("conversion did not last sixteen clocks");

  AST_SINGLE_MUX: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    in_conv && byte_hold_reg.sgl |-> mux_reg.common_return_input && mux_reg.neg == 8'h00
      && mux_reg.pos == (8'h01 << byte_hold_reg.chan))
    else $error("single-ended routing wrong");

  AST_DIFF_MUX: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    in_conv && !byte_hold_reg.sgl |-> !mux_reg.common_return_input && $onehot(mux_reg.pos)
      && mux_reg.neg == (byte_hold_reg.chan[2] ? (mux_reg.pos >> 1) : (mux_reg.pos << 1)))
    else $error("differential routing wrong");

  AST_MUX_STABLE: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    in_conv |=> $stable(mux_reg))
    else $error("multiplexer changed during conversion");

  AST_START_WAIT: assert property (@(posedge serial_clock_in_i) disable iff (frame_rst)
    phase_reg == SAS_IDLE && !din_i |=> phase_reg == SAS_IDLE && !acq_reg)
    else $error("frame started without a start bit");

  AST_BUSY_ONE: assert property (@(negedge serial_clock_in_i) disable iff (frame_rst)
    $rose(busy_reg) |=> !busy_reg && in_conv && cnt_reg == 5'h02)
    else $error("busy not exactly one clock");

  AST_OE_OFF: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    cs_sync_reg |=> !dout_oe_o && !busy_oe_o)
    else $error("outputs driven with chip select high");

endmodule : sas_sequencer

//--- sas_host_model.sv
`timescale 1ns/1ps
module sas_host_model
  import sas_pkg::*;
(
  // Link pins
  output logic             serial_clock_in_o,
  output logic             cs_n_o,
  output logic             din_o,
  input  wire logic        dout_i,
  input  wire logic        busy_i,
  // Front end stand-in
  input  wire logic [15:0] dac_trial_i,
  input  wire logic        acquire_i,
  input  wire logic        hold_i,
  input  wire sas_mux_t    mux_i,
  output logic             comp_o
);
  logic [15:0] held_reg;
  logic [15:0] shift_reg;
  logic        pend_reg;
  logic [25:0] acq_s;
  logic [25:0] hold_s;
  logic [25:0] busy_s;
  sas_mux_t    mux_s;
  sas_mux_t    mux_e;
  logic [15:0] rx_q[$];

  // Ideal comparator, so a correct search returns the held value exactly
  assign comp_o = (held_reg >= dac_trial_i);

  initial begin
    serial_clock_in_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    held_reg = 16'h0000;
    shift_reg = 16'h0000;
    pend_reg = 1'b0;
  end

  // Clock stands low between frames; everything is sampled just before the rise
  task automatic tick(input logic d, input int k);
    logic lsb;
    lsb = (k == 25) || (k == 1 && pend_reg);
    din_o = d;
    #40;
    if ((k >= 10 && k <= 24) || lsb) shift_reg = {shift_reg[14:0], dout_i};
    if (lsb) rx_q.push_back(shift_reg);
    acq_s[k] = acquire_i;
    hold_s[k] = hold_i;
    busy_s[k] = busy_i;
    if (k == 12) mux_s = mux_i;
    if (k == 24) mux_e = mux_i;
    serial_clock_in_o = 1'b1;
    #40 serial_clock_in_o = 1'b0;
  endtask : tick

  // Back-to-back frames: the next start bit shares the edge that takes the LSB
  task automatic frame(input logic [7:0] ctrl, input logic [15:0] held, input int lead);
    held_reg = held;
    cs_n_o = 1'b0;
    for (int i = 0; i < lead; i++) tick(1'b0, 0);
    for (int k = 1; k <= 24; k++) tick((k <= 8) ? ctrl[8 - k] : 1'b0, k);
    pend_reg = 1'b1;
  endtask : frame

  task automatic finish_seq();
    tick(1'b0, 25);
    pend_reg = 1'b0;
    #40 cs_n_o = 1'b1;
  endtask : finish_seq
endmodule : sas_host_model

//--- sas_sequencer_tb.sv
`timescale 1ns/1ps
module sas_sequencer_tb;
  import sas_pkg::*;
  logic        clk_sys_i;
  logic        srst_i;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic        serial_clock_in_i;
  logic        cs_n_i;
  logic        din_i;
  logic        dout_o;
  logic        busy_o;
  logic        dout_oe_o;
  logic        busy_oe_o;
  logic        comp_i;
  logic        acquire_o;
  logic        hold_o;
  logic        powered_o;
  logic [15:0] dac_trial_o;
  logic [1:0]  pwr_mode_o;
  sas_mux_t    mux_o;
  int          mismatches;
  int          total_checks;
  logic [31:0] rd;
  logic [7:0]  ctrl;

  sas_sequencer dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .serial_clock_in_i(serial_clock_in_i), .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .busy_o(busy_o), .busy_oe_o(busy_oe_o), .comp_i(comp_i), .dac_trial_o(dac_trial_o),
    .mux_o(mux_o), .acquire_o(acquire_o), .hold_o(hold_o), .powered_o(powered_o), .pwr_mode_o(pwr_mode_o));

  sas_host_model host_u (.serial_clock_in_o(serial_clock_in_i), .cs_n_o(cs_n_i), .din_o(din_i),
    .dout_i(dout_o), .busy_i(busy_o), .dac_trial_i(dac_trial_o), .acquire_i(acquire_o),
    .hold_i(hold_o), .mux_i(mux_o), .comp_o(comp_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_read

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic check_bit(input string name, input logic exp, input logic got);
    check(name, {31'h0, exp}, {31'h0, got});
  endtask : check_bit

  function automatic sas_mux_t exp_mux(input logic [2:0] ch, input logic sgl);
    sas_mux_t m;
    m = '0;
    if (sgl) begin
      m.pos = 8'h01 << ch;
      m.common_return_input = 1'b1;
    end else begin
      m.pos = 8'h01 << {ch[1:0], ch[2]};
      m.neg = 8'h01 << {ch[1:0], ~ch[2]};
    end
    return m;
  endfunction : exp_mux

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Expected run is about 43 us
  initial begin
    #300000;
    mismatches++;
    conclude();
  end

  initial begin
    srst_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    reg_read(SAS_OFS_CTRL, rd);
    check("ctrl", 32'h1, rd);
    reg_write(SAS_OFS_RES, 32'hffff);
    reg_read(SAS_OFS_RES, rd);
    check("result", 32'h0, rd);
    // Every channel code in both input modes, one unbroken run
    for (int i = 0; i < 16; i++) begin
      ctrl = {1'b1, i[2:0], 1'b0, i[3], 2'b11};
      host_u.frame(ctrl, 16'(i * 16'h1111), (i == 0) ? 3 : 0);
      check("mux", {15'h0, exp_mux(i[2:0], i[3])}, {15'h0, host_u.mux_s});
      check("mux held", {15'h0, host_u.mux_s}, {15'h0, host_u.mux_e});
      check_bit("acq4", 1'b0, host_u.acq_s[4]);
      check_bit("acq5", 1'b1, host_u.acq_s[5]);
      check_bit("acq8", 1'b1, host_u.acq_s[8]);
      check_bit("acq9", 1'b0, host_u.acq_s[9]);
      check_bit("hold8", 1'b0, host_u.hold_s[8]);
      check_bit("hold9", 1'b1, host_u.hold_s[9]);
      check_bit("hold24", 1'b1, host_u.hold_s[24]);
      check_bit("busy8", 1'b0, host_u.busy_s[8]);
      check_bit("busy9", 1'b1, host_u.busy_s[9]);
      check_bit("busy10", 1'b0, host_u.busy_s[10]);
    end
    host_u.finish_seq();
    repeat (10) @(posedge clk_sys_i);
    check("rx count", 32'd16, host_u.rx_q.size());
    for (int i = 0; i < 16; i++) check("dout", 32'(i * 32'h1111), {16'h0, host_u.rx_q[i]});
    reg_read(SAS_OFS_RES, rd);
    check("result", 32'hffff, rd);
    reg_read(SAS_OFS_CNT, rd);
    check("count", 32'd16, rd);
    reg_read(SAS_OFS_STAT, rd);
    check("stat", {24'h0, ctrl}, rd);
    for (int p = 0; p < 4; p++) begin
      fork
        host_u.frame({6'b100001, p[1:0]}, 16'h00ff, 2);
        begin
          // Well inside the frame: chip select synchronised, start bit taken
          repeat (60) @(posedge clk_sys_i);
          #1;
          check_bit("dout oe", 1'b1, dout_oe_o);
          check_bit("busy oe", 1'b1, busy_oe_o);
          check_bit("powered run", 1'b1, powered_o);
        end
      join
      host_u.finish_seq();
      repeat (10) @(posedge clk_sys_i);
      check("pwr", {30'h0, p[1:0]}, {30'h0, pwr_mode_o});
      check_bit("powered", p != 0, powered_o);
      check_bit("oe off", 1'b0, dout_oe_o);
      check_bit("busy oe off", 1'b0, busy_oe_o);
    end
    // Start bits must be ignored while detection is off
    reg_write(SAS_OFS_CTRL, 32'h0);
    host_u.frame(8'hff, 16'h0, 4);
    host_u.finish_seq();
    repeat (10) @(posedge clk_sys_i);
    check_bit("acq off", 1'b0, host_u.acq_s[5]);
    reg_read(SAS_OFS_CNT, rd);
    check("count", 32'd20, rd);
    reg_write(SAS_OFS_CTRL, 32'h1);
    conclude();
  end
endmodule : sas_sequencer_tb
